//--- include/adc_ctl_pkg.sv
// shared constants and types for the converter control and the core-side end
package adc_ctl_pkg;

  // ************************************************************
  // converter register offsets, seen through the link
  // ************************************************************
  localparam logic [5:0] OFS_RESULT_LOW   = 6'h19;
  localparam logic [5:0] OFS_RESULT_HIGH  = 6'h1A;
  localparam logic [5:0] OFS_CHAN_REF     = 6'h1B;
  localparam logic [5:0] OFS_CTRL_B       = 6'h1C;
  localparam logic [5:0] OFS_CTRL_STATUS  = 6'h1D;

  // ************************************************************
  // core-side registers
  // ************************************************************
  localparam logic [5:0] OFS_SLEEP_CTRL   = 6'h35;
  localparam logic [5:0] OFS_CORE_STATUS  = 6'h36;
  localparam logic [5:0] OFS_IRQ_GLOBAL   = 6'h3F;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BIT_ENABLE     = 7;
  localparam int BIT_START      = 6;
  localparam int BIT_AUTO_TRIG  = 5;
  localparam int BIT_DONE_FLAG  = 4;
  localparam int BIT_DONE_IE    = 3;
  localparam int BIT_LEFT_ADJ   = 7;
  localparam int BIT_SLEEP_GO   = 0;
  localparam int BIT_GLOBAL_IE  = 7;

  // ************************************************************
  // reset values and conversion figures
  // ************************************************************
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam int         RESULT_W       = 10;
  localparam int         FULL_SCALE     = 1024;
  localparam logic [9:0] CODE_MAX       = 10'h3FF;
  localparam int         NORMAL_CYCLES  = 15;
  localparam int         FIRST_CYCLES   = 26;

  // sleep states the core may enter
  typedef enum logic [1:0] {
    SLP_IDLE,
    SLP_NOISE_RED,
    SLP_POWER_DOWN,
    SLP_STANDBY
  } sleep_mode_t;

endpackage

//--- include/adc_link_if.sv
// link between the processor core end and the converter control end
`timescale 1ns/10ps
interface adc_link_if;
  import adc_ctl_pkg::*;

  logic [5:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  sleep_mode_t sleep_mode;
  logic        halted;
  logic        irq_req;
  logic        irq_ack;

  modport dev (
    input  addr, wdata, wr, rd, sleep_mode, halted, irq_ack,
    output rdata, irq_req
  );

  modport core (
    output addr, wdata, wr, rd, sleep_mode, halted, irq_ack,
    input  rdata, irq_req
  );
endinterface

//--- rtl/adc_core_end.sv
// core-side end: register access, sleep entry, wake-up and vector acknowledge
`timescale 1ns/10ps
module adc_core_end
  import adc_ctl_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // software register port
  input  wire logic [5:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic      [7:0] sw_rdata,
  // other interrupt sources and events
  input  wire logic       other_irq,
  output logic            done_vector,
  output logic            other_vector,
  output logic            core_halted,
  // link to the converter
  adc_link_if.core        link
);

  logic        halted_r;
  sleep_mode_t mode_r;
  logic        gie_r;
  logic        ack_r;
  logic        other_vec_r;
  logic        local_rd_r;
  logic [7:0]  local_rdata_r;
  logic        is_local;
  logic        take_done;
  logic        take_other;

  assign is_local = (sw_addr == OFS_SLEEP_CTRL) || (sw_addr == OFS_CORE_STATUS)
                    || (sw_addr == OFS_IRQ_GLOBAL);

  // ************************************************************
  // interrupt acceptance; other sources win the wake race
  // ************************************************************
  assign take_other = other_irq && gie_r && !ack_r && !other_vec_r;
  assign take_done  = link.irq_req && gie_r && !take_other && !ack_r && !other_vec_r;

  // global interrupt enable
  always_ff @(posedge clk) begin
    if (rst)                                      gie_r <= 1'b0;
    else if (sw_wr && (sw_addr == OFS_IRQ_GLOBAL)) gie_r <= sw_wdata[BIT_GLOBAL_IE];
  end

  // sleep entry on command, leave on any accepted interrupt
  always_ff @(posedge clk) begin
    if (rst) begin
      halted_r <= 1'b0;
      mode_r   <= SLP_IDLE;
    end else if (take_done || take_other) begin
      halted_r <= 1'b0;                          // stays awake until next sleep
    end else if (sw_wr && (sw_addr == OFS_SLEEP_CTRL) && sw_wdata[BIT_SLEEP_GO]) begin
      halted_r <= 1'b1;
      mode_r   <= sleep_mode_t'(sw_wdata[2:1]);
    end
  end

  // vector pulses; the done vector clears the converter flag
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_r       <= 1'b0;
      other_vec_r <= 1'b0;
    end else begin
      ack_r       <= take_done;
      other_vec_r <= take_other;
    end
  end

  // local register reads
  always_ff @(posedge clk) begin
    if (rst) begin
      local_rd_r    <= 1'b0;
      local_rdata_r <= REG_RESET;
    end else begin
      local_rd_r <= sw_rd && is_local;
      if (sw_rd && (sw_addr == OFS_CORE_STATUS))
        local_rdata_r <= {5'h00, mode_r, halted_r};
      else if (sw_rd && (sw_addr == OFS_IRQ_GLOBAL))
        local_rdata_r <= {gie_r, 7'h00};
      else
        local_rdata_r <= REG_RESET;
    end
  end

  // forward converter accesses over the link
  assign link.addr       = sw_addr;
  assign link.wdata      = sw_wdata;
  assign link.wr         = sw_wr && !is_local;
  assign link.rd         = sw_rd && !is_local;
  assign link.sleep_mode = mode_r;
  assign link.halted     = halted_r;
  assign link.irq_ack    = ack_r;

  assign sw_rdata     = local_rd_r ? local_rdata_r : link.rdata;
  assign done_vector  = ack_r;
  assign other_vector = other_vec_r;
  assign core_halted  = halted_r;

endmodule // adc_core_end

//--- rtl/adc_sleep_conv.sv
// converter control: sleep-started conversion, completion flag, locked result readout
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/10ps

module adc_sleep_conv
  import adc_ctl_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // link to the core
  adc_link_if.dev                  link,
  // analog side
  input  wire logic [RESULT_W-1:0] sar_code,
  output logic      [2:0]          channel_sel,
  output logic      [1:0]          reference_sel,
  output logic                     analog_power,
  output logic                     conv_active
);

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} conv_state_t;

  // ************************************************************
  // decoding helpers
  // ************************************************************

  // last prescaler count for a division setting
  function automatic logic [6:0] presc_last(input logic [2:0] ps);
    logic [7:0] div;
    div = (ps < 3'h2) ? 8'h02 : (8'h01 << ps);
    return 7'(div - 8'h01);
  endfunction

  // byte of the result as software sees it
  function automatic logic [7:0] result_byte(input logic [9:0] r, input logic ladj,
                                             input logic high);
    logic [15:0] word;
    word = ladj ? {r, 6'h00} : {6'h00, r};
    return high ? word[15:8] : word[7:0];
  endfunction

  // ************************************************************
  // registers
  // ************************************************************
  conv_state_t   state_r;
  logic          enable_r;
  logic          auto_trig_r;
  logic          done_flag_r;
  logic          done_ie_r;
  logic [2:0]    presc_sel_r;
  logic          left_adj_r;
  logic [2:0]    trig_src_r;
  logic [2:0]    chan_buf_r;
  logic [1:0]    ref_buf_r;
  logic [2:0]    chan_r;
  logic [1:0]    ref_r;
  logic [6:0]    presc_cnt_r;
  logic [4:0]    cyc_r;
  logic          first_r;
  logic          conv_first_r;
  logic [9:0]    result_r;
  logic          lock_r;
  logic          halted_q_r;
  logic [7:0]    rdata_r;

  logic          wr_ctrl;
  logic          tick;
  logic          finish;
  logic          sleep_start;
  logic          sw_start;
  logic [4:0]    conv_last;

  assign wr_ctrl   = link.wr && (link.addr == OFS_CTRL_STATUS);
  assign tick      = enable_r && (presc_cnt_r >= presc_last(presc_sel_r)); // no wrap on a smaller divider
  assign conv_last = conv_first_r ? 5'(FIRST_CYCLES - 1) : 5'(NORMAL_CYCLES - 1);
  assign finish    = (state_r == ST_CONV) && tick && (cyc_r == conv_last);

  // software start: a one written to the start bit with the enable bit set in the same write, while idle
  assign sw_start = wr_ctrl && link.wdata[BIT_START] && link.wdata[BIT_ENABLE]
                    && (state_r == ST_IDLE);

  // core has just halted in idle or noise-reduction sleep with the converter ready
  assign sleep_start = link.halted && !halted_q_r
                       && ((link.sleep_mode == SLP_IDLE)
                           || (link.sleep_mode == SLP_NOISE_RED))
                       && enable_r && !auto_trig_r && (state_r == ST_IDLE);

  // ************************************************************
  // control and configuration registers
  // ************************************************************

  // control/status fields other than the flag and the start bit
  always_ff @(posedge clk) begin
    if (rst) begin
      enable_r    <= 1'b0;
      auto_trig_r <= 1'b0;
      done_ie_r   <= 1'b0;
      presc_sel_r <= 3'h0;
    end else if (wr_ctrl) begin
      enable_r    <= link.wdata[BIT_ENABLE];
      auto_trig_r <= link.wdata[BIT_AUTO_TRIG];
      done_ie_r   <= link.wdata[BIT_DONE_IE];
      presc_sel_r <= link.wdata[2:0];
    end
  end

  // control b and channel/reference buffers
  always_ff @(posedge clk) begin
    if (rst) begin
      left_adj_r <= 1'b0;
      trig_src_r <= 3'h0;
      chan_buf_r <= 3'h0;
      ref_buf_r  <= 2'h0;
    end else if (link.wr) begin
      if (link.addr == OFS_CTRL_B) begin
        left_adj_r <= link.wdata[BIT_LEFT_ADJ];
        trig_src_r <= link.wdata[2:0];
      end
      if (link.addr == OFS_CHAN_REF) begin
        chan_buf_r <= link.wdata[2:0];
        ref_buf_r  <= link.wdata[7:6];
      end
    end
  end

  // selection follows the buffer except while a conversion runs
  always_ff @(posedge clk) begin
    if (rst) begin
      chan_r <= 3'h0;
      ref_r  <= 2'h0;
    end else if (state_r != ST_CONV) begin
      chan_r <= chan_buf_r;
      ref_r  <= ref_buf_r;
    end
  end

  // ************************************************************
  // prescaler and conversion sequencing
  // ************************************************************

  // prescaler runs while enabled, held clear otherwise
  always_ff @(posedge clk) begin
    if (rst || !enable_r || tick) presc_cnt_r <= 7'h00;
    else                           presc_cnt_r <= presc_cnt_r + 7'h01;
  end

  // sequencer: a request waits for the next converter clock edge
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r      <= ST_IDLE;
      cyc_r        <= 5'h00;
      conv_first_r <= 1'b0;
    end else if (wr_ctrl && !link.wdata[BIT_ENABLE]) begin
      state_r <= ST_IDLE;                       // disabling ends any conversion
    end else begin
      unique case (state_r)
        ST_IDLE: if (sw_start || sleep_start) state_r <= ST_WAIT;
        ST_WAIT: if (tick) begin
          state_r      <= ST_CONV;
          cyc_r        <= 5'h00;
          conv_first_r <= first_r;
        end
        ST_CONV: if (tick) begin
          if (finish) state_r <= ST_IDLE;
          else        cyc_r   <= cyc_r + 5'h01;
        end
      endcase
    end
  end

  // first conversion after enabling is the long one
  always_ff @(posedge clk) begin
    if (rst)                                                 first_r <= 1'b1;
    else if (!enable_r || (wr_ctrl && !link.wdata[BIT_ENABLE])) first_r <= 1'b1;
    else if ((state_r == ST_WAIT) && tick)                   first_r <= 1'b0;
  end

  // remember the halt level to find its rising edge
  always_ff @(posedge clk) begin
    if (rst) halted_q_r <= 1'b0;
    else     halted_q_r <= link.halted;
  end

  // ************************************************************
  // completion flag and result
  // ************************************************************

  // set by completion; cleared by vector or written one; set wins
  always_ff @(posedge clk) begin
    if (rst)                                                  done_flag_r <= 1'b0;
    else if (finish)                                          done_flag_r <= 1'b1;
    else if (link.irq_ack || (wr_ctrl && link.wdata[BIT_DONE_FLAG])) done_flag_r <= 1'b0;
  end

  // result captured at completion unless the low byte froze it
  always_ff @(posedge clk) begin
    if (rst)                     result_r <= 10'h000;
    else if (finish && !lock_r)  result_r <= sar_code;
  end

  // low-byte read locks, high-byte read unlocks
  always_ff @(posedge clk) begin
    if (rst)                                               lock_r <= 1'b0;
    else if (link.rd && (link.addr == OFS_RESULT_LOW))     lock_r <= 1'b1;
    else if (link.rd && (link.addr == OFS_RESULT_HIGH))    lock_r <= 1'b0;
  end

  // ************************************************************
  // read port: data one cycle after the strobe
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= REG_RESET;
    end else if (link.rd) begin
      unique case (link.addr)
        OFS_RESULT_LOW:  rdata_r <= result_byte(result_r, left_adj_r, 1'b0);
        OFS_RESULT_HIGH: rdata_r <= result_byte(result_r, left_adj_r, 1'b1);
        OFS_CHAN_REF:    rdata_r <= {ref_buf_r, 3'h0, chan_buf_r};
        OFS_CTRL_B:      rdata_r <= {left_adj_r, 4'h0, trig_src_r};
        OFS_CTRL_STATUS: rdata_r <= {enable_r, (state_r != ST_IDLE), auto_trig_r,
                                     done_flag_r, done_ie_r, presc_sel_r};
        default:         rdata_r <= REG_RESET;
      endcase
    end else begin
      rdata_r <= REG_RESET;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign link.rdata    = rdata_r;
  assign link.irq_req  = done_flag_r && done_ie_r;
  assign analog_power  = enable_r;
  assign conv_active   = (state_r == ST_CONV);
  assign channel_sel   = chan_r;
  assign reference_sel = ref_r;

endmodule // adc_sleep_conv

//--- tb/adc_link_checker.sv
// concurrent checks on the link between the core end and the converter control
`timescale 1ns/10ps
module adc_link_checker
  import adc_ctl_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // link signals
  input wire logic [5:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire sleep_mode_t sleep_mode,
  input wire logic        halted,
  input wire logic        irq_req,
  input wire logic        irq_ack
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ****************************************
  // register traffic
  // ****************************************
  strobe_excl_a: assert property (!(wr && rd))
    else $error("read and write strobes together");
  read_quiet_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside the answer cycle");

  // ****************************************
  // sleep, wake and acknowledge
  // ****************************************
  ack_pulse_a: assert property (irq_ack |=> !irq_ack)
    else $error("acknowledge longer than one cycle");
  ack_cause_a: assert property (irq_ack |-> $past(irq_req))
    else $error("acknowledge without request");
  ack_clears_a: assert property (irq_ack |=> !irq_req)
    else $error("request still up after acknowledge");
  wake_done_a: assert property (halted && irq_req |-> ##[1:3] !halted)
    else $error("completion did not wake the core");
  ack_wakes_a: assert property (irq_ack |=> !halted)
    else $error("core halted after acknowledge");
  mode_hold_a: assert property (halted && $past(halted) |-> $stable(sleep_mode))
    else $error("sleep mode changed while halted");
  req_holds_a: assert property ($fell(irq_req) |->
      $past(irq_ack || (wr && addr == OFS_CTRL_STATUS)))
    else $error("request dropped without acknowledge or clear");
endmodule // adc_link_checker

//--- tb/tb_top.sv
// self-checking bench joining the core end and the converter control
`timescale 1ns/10ps
module tb_top
  import adc_ctl_pkg::*;
;
  logic       clk, rst, sw_wr, sw_rd, other_irq;
  logic       done_vector, other_vector, core_halted, analog_power, conv_active;
  logic [5:0] sw_addr;
  logic [7:0] sw_wdata, sw_rdata, rv, lo, hi;
  logic [9:0] sar_code, code;
  logic [2:0] channel_sel;
  logic [1:0] reference_sel;
  int         bad_count, checks, seed, dv_cnt, ov_cnt, act_cnt, last_len, t;
  logic [5:0] reg_list [6] = '{OFS_RESULT_LOW, OFS_RESULT_HIGH, OFS_CHAN_REF,
                               OFS_CTRL_B, OFS_CTRL_STATUS, 6'h00};

  // ****************************************
  // design, link and checker
  // ****************************************
  adc_link_if link ();
  adc_sleep_conv i_adc_sleep_conv (.clk(clk), .rst(rst), .link(link.dev),
    .sar_code(sar_code), .channel_sel(channel_sel), .reference_sel(reference_sel),
    .analog_power(analog_power), .conv_active(conv_active));
  adc_core_end i_adc_core_end (.clk(clk), .rst(rst), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .other_irq(other_irq), .done_vector(done_vector), .other_vector(other_vector),
    .core_halted(core_halted), .link(link.core));
  adc_link_checker i_adc_link_checker (.clk(clk), .rst(rst), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
    .sleep_mode(link.sleep_mode), .halted(link.halted), .irq_req(link.irq_req),
    .irq_ack(link.irq_ack));

  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // count vectors and measure converting time
  always @(posedge clk) begin
    if (done_vector === 1'b1) dv_cnt++;
    if (other_vector === 1'b1) ov_cnt++;
    if (conv_active === 1'b1) act_cnt++;
    else if (act_cnt != 0) begin
      last_len = act_cnt;
      act_cnt = 0;
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    {sw_addr, sw_wdata, sw_wr} <= {a, d, 1'b1};
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    {sw_addr, sw_rd} <= {a, 1'b1};
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask

  // high byte then low byte as presented
  function automatic logic [15:0] pair_of(input logic [9:0] c, input logic left);
    return left ? {c, 6'h00} : {6'h00, c};
  endfunction

  task automatic wait_for(ref int cnt, input int goal);
    for (int k = 0; k < 500 && cnt < goal; k++) @(posedge clk);
  endtask

  task automatic read_result(input logic [15:0] exp);
    rd_reg(OFS_RESULT_LOW, lo);
    rd_reg(OFS_RESULT_HIGH, hi);
    chk({hi, lo}, exp);
  endtask

  // software-started conversion, timed, then flag cleared
  task automatic convert(input logic [9:0] c, input logic [2:0] ps, input logic left,
                         input int ticks);
    sar_code <= c;
    wr_reg(OFS_CTRL_B, {left, 7'h00});
    wr_reg(OFS_CTRL_STATUS, {5'b11000, ps});
    rd_reg(OFS_CTRL_STATUS, rv);
    chk(16'(rv[BIT_START]), 16'h0001);
    for (int k = 0; k < 400 && rv[BIT_START] !== 1'b0; k++) rd_reg(OFS_CTRL_STATUS, rv);
    chk(16'({rv[BIT_START], rv[BIT_DONE_FLAG]}), 16'h0001);
    chk(16'(last_len), 16'(ticks * ((ps < 3'h2) ? 2 : (1 << ps))));
    wr_reg(OFS_CTRL_STATUS, 8'h90);
    rd_reg(OFS_CTRL_STATUS, rv);
    chk(16'(rv[BIT_DONE_FLAG]), 16'h0000);
  endtask

  task automatic wake_other();
    int w;
    w = ov_cnt + 1;
    other_irq <= 1'b1;
    // drop the request at the edge that first shows the vector, so it is taken once
    for (int k = 0; k < 500 && other_vector !== 1'b1; k++) @(posedge clk);
    other_irq <= 1'b0;
    #1 chk(16'(ov_cnt), 16'(w));
    chk(16'(core_halted), 16'h0000);
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #400000;
    bad_count++;
    conclude();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst, sw_wr, sw_rd, other_irq, sw_addr, sw_wdata, sar_code} = '0;
    rst = 1'b1;
    seed = 98;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (reg_list[i]) begin
      rd_reg(reg_list[i], rv);
      chk(16'(rv), 16'(REG_RESET));
    end
    // channel and reference follow their buffer while idle
    wr_reg(OFS_CHAN_REF, 8'hC5);
    @(posedge clk) #1 chk(16'({reference_sel, channel_sel}), 16'h001D);
    rd_reg(OFS_CHAN_REF, rv);
    chk(16'(rv), 16'h00C5);
    wr_reg(OFS_IRQ_GLOBAL, 8'h80);
    convert(CODE_MAX, 3'h0, 1'b0, FIRST_CYCLES);
    read_result(pair_of(CODE_MAX, 1'b0));
    for (int i = 0; i < 6; i++) begin
      code = (i == 0) ? 10'h000 : 10'($random(seed));
      convert(code, 3'(i % 3), i[0], NORMAL_CYCLES);
      read_result(pair_of(code, i[0]));
    end
    // locked result keeps the older conversion
    convert(10'h155, 3'h0, 1'b0, NORMAL_CYCLES);
    rd_reg(OFS_RESULT_LOW, lo);
    convert(10'h2AA, 3'h0, 1'b0, NORMAL_CYCLES);
    rd_reg(OFS_RESULT_HIGH, hi);
    chk({hi, lo}, pair_of(10'h155, 1'b0));
    convert(10'h2AA, 3'h0, 1'b0, NORMAL_CYCLES);
    read_result(pair_of(10'h2AA, 1'b0));
    // every sleep state, converter enabled with completion interrupt
    wr_reg(OFS_CTRL_STATUS, 8'h88);
    for (int m = 0; m < 4; m++) begin
      code = 10'($random(seed));
      sar_code <= code;
      t = dv_cnt + 1;
      wr_reg(OFS_SLEEP_CTRL, {5'h00, 2'(m), 1'b1});
      @(posedge clk) #1 chk(16'(core_halted), 16'h0001);
      if (m < 2) begin
        wait_for(dv_cnt, t);
        chk(16'(dv_cnt), 16'(t));
        chk(16'(last_len), 16'(2 * NORMAL_CYCLES));
        read_result(pair_of(code, 1'b0));
      end else begin
        repeat (40) @(posedge clk);
        #1 chk(16'({analog_power, conv_active, core_halted}), 16'h0005);
        wake_other();
      end
    end
    // auto trigger selected: sleep must not start a conversion
    wr_reg(OFS_CTRL_STATUS, 8'hA8);
    wr_reg(OFS_SLEEP_CTRL, 8'h01);
    repeat (40) @(posedge clk);
    #1 chk(16'({conv_active, core_halted}), 16'h0001);
    wake_other();
    wr_reg(OFS_CTRL_STATUS, 8'h88);
    // another interrupt wakes first, completion still requested
    code = 10'($random(seed));
    sar_code <= code;
    t = dv_cnt + 1;
    wr_reg(OFS_SLEEP_CTRL, 8'h03);
    repeat (4) @(posedge clk);
    wake_other();
    chk(16'(dv_cnt), 16'(t - 1));
    chk(16'(conv_active), 16'h0001);
    wait_for(dv_cnt, t);
    chk(16'(dv_cnt), 16'(t));
    read_result(pair_of(code, 1'b0));
    conclude();
  end
endmodule // tb_top
